// file: core/halfword_load_decode.sv
// Halfword load unit: decode, address, one memory read, register commit.
`timescale 1ns/1ns
module halfword_load_decode
   import hload_pkg::*;
#(
   parameter int XLEN = 32
)(
   // Clock and synchronous active-low reset.
   input  wire logic        REF_CLK_IN,
   input  wire logic        NRST_IN,
   // Instruction stream.
   input  wire logic        INSTR_VALID_IN,
   input  wire logic [31:0] INSTR_IN,
   output logic             INSTR_READY_OUT,
   output logic             ILLEGAL_OUT,
   // Register file read selects and data.
   output logic [4:0]       BASE_SEL_OUT,
   output logic [4:0]       INDEX_SEL_OUT,
   input  wire logic [31:0] BASE_DATA_IN,
   input  wire logic [31:0] INDEX_DATA_IN,
   // Data memory read.
   output logic             MEM_REQ_OUT,
   output logic [31:0]      MEM_ADDR_OUT,
   input  wire logic        MEM_ACK_IN,
   input  wire logic [15:0] MEM_DATA_IN,
   input  wire logic        MEM_ERR_IN,
   // Register file writes.
   output logic             TGT_WE_OUT,
   output logic [4:0]       TGT_SEL_OUT,
   output logic [31:0]      TGT_DATA_OUT,
   output logic             BASE_WE_OUT,
   output logic [31:0]      BASE_DATA_OUT,
   // Completion status.
   output logic             DONE_OUT,
   output logic             ALIGN_FAULT_OUT,
   output logic             STORAGE_FAULT_OUT
);

   // The datapath is built for 32-bit registers only.
   if (XLEN != 32) begin : g_xlen_check
      $error("halfword_load_decode supports XLEN of 32 only");
   end

   ////////////////////////////////////////////////////////////////////////
   // Decoder instance and shared arithmetic.

   decode_type dec;

   hload_decoder u_dec (
      .instr_in (INSTR_IN),
      .dec_out  (dec)
   );

   // A zero base field means the literal value zero, not register 0.
   function automatic logic [31:0] ea_calc(input logic [4:0]  base_sel,
                                           input logic [31:0] base_val,
                                           input logic [31:0] operand);
      if (base_sel == SEL_RESET) ea_calc = operand;
      else                       ea_calc = base_val + operand;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // State and next-state signals.

   state_type   state_reg,   state_next;
   decode_type  op_reg,      op_next;
   logic [31:0] ea_reg,      ea_next;
   logic [15:0] half_reg,    half_next;
   logic        req_reg,     req_next;
   logic        tgt_we_reg,  tgt_we_next;
   logic        base_we_reg, base_we_next;
   logic [31:0] tgt_dat_reg, tgt_dat_next;
   logic        done_reg,    done_next;
   logic        align_reg,   align_next;
   logic        stor_reg,    stor_next;
   logic        ill_reg,     ill_next;
   logic [31:0] offset;
   logic        accept;

   assign accept = INSTR_VALID_IN && INSTR_READY_OUT;
   // Offset is sign-extended for displacement forms.
   assign offset = op_reg.indexed ? INDEX_DATA_IN
                 : {{16{op_reg.imm[15]}}, op_reg.imm};

   ////////////////////////////////////////////////////////////////////////
   // Sequencer: accept, address, read, commit.
   always_comb begin
      state_next   = state_reg;
      op_next      = op_reg;
      ea_next      = ea_reg;
      half_next    = half_reg;
      req_next     = req_reg;
      tgt_we_next  = 1'b0;
      base_we_next = 1'b0;
      tgt_dat_next = tgt_dat_reg;
      done_next    = 1'b0;
      align_next   = 1'b0;
      stor_next    = 1'b0;
      ill_next     = 1'b0;
      unique case (state_reg)
         ST_IDLE: begin
            if (accept) begin
               op_next = dec;
               if (dec.legal) state_next = ST_ADDR;
               else           ill_next   = 1'b1;
            end
         end
         ST_ADDR: begin
            ea_next = ea_calc(op_reg.base, BASE_DATA_IN,
                              offset);
            // An odd halfword address faults before any memory access.
            if (ea_next[0]) begin
               align_next = 1'b1;
               done_next  = 1'b1;
               state_next = ST_IDLE;
            end else begin
               req_next   = 1'b1;
               state_next = ST_READ;
            end
         end
         ST_READ: begin
            if (MEM_ACK_IN) begin
               req_next = 1'b0;
               if (MEM_ERR_IN) begin
                  stor_next  = 1'b1;
                  done_next  = 1'b1;
                  state_next = ST_IDLE;
               end else begin
                  half_next  = MEM_DATA_IN;
                  state_next = ST_COMMIT;
               end
            end
         end
         ST_COMMIT: begin
            // Only general registers are written; flags stay untouched.
            tgt_we_next = 1'b1;
            if (op_reg.swap)
               tgt_dat_next = {16'h0000, half_reg[7:0],
                               half_reg[15:8]};
            else
               tgt_dat_next = {16'h0000, half_reg};
            base_we_next = op_reg.update && (op_reg.base != SEL_RESET) &&
                           (op_reg.base != op_reg.tgt);
            done_next  = 1'b1;
            state_next = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge REF_CLK_IN) begin
      if (!NRST_IN) begin
         state_reg   <= ST_IDLE;
         op_reg      <= DECODE_RESET;
         ea_reg      <= WORD_RESET;
         half_reg    <= HALF_RESET;
         req_reg     <= 1'b0;
         tgt_we_reg  <= 1'b0;
         base_we_reg <= 1'b0;
         tgt_dat_reg <= WORD_RESET;
         done_reg    <= 1'b0;
         align_reg   <= 1'b0;
         stor_reg    <= 1'b0;
         ill_reg     <= 1'b0;
      end else begin
         state_reg   <= state_next;
         op_reg      <= op_next;
         ea_reg      <= ea_next;
         half_reg    <= half_next;
         req_reg     <= req_next;
         tgt_we_reg  <= tgt_we_next;
         base_we_reg <= base_we_next;
         tgt_dat_reg <= tgt_dat_next;
         done_reg    <= done_next;
         align_reg   <= align_next;
         stor_reg    <= stor_next;
         ill_reg     <= ill_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs; every data output comes from a flip-flop.
   assign INSTR_READY_OUT   = (state_reg == ST_IDLE);
   assign ILLEGAL_OUT       = ill_reg;
   assign BASE_SEL_OUT      = op_reg.base;
   assign INDEX_SEL_OUT     = op_reg.index;
   assign MEM_REQ_OUT       = req_reg;
   assign MEM_ADDR_OUT      = ea_reg;
   assign TGT_WE_OUT        = tgt_we_reg;
   assign TGT_SEL_OUT       = op_reg.tgt;
   assign TGT_DATA_OUT      = tgt_dat_reg;
   assign BASE_WE_OUT       = base_we_reg;
   assign BASE_DATA_OUT     = ea_reg;
   assign DONE_OUT          = done_reg;
   assign ALIGN_FAULT_OUT   = align_reg;
   assign STORAGE_FAULT_OUT = stor_reg;

   ////////////////////////////////////////////////////////////////////////
   // Assertions and covers.
   default clocking cb @(posedge REF_CLK_IN); endclocking
   default disable iff (!NRST_IN);

   swap_data_a: assert property (TGT_WE_OUT && op_reg.swap |->
      TGT_DATA_OUT == {16'h0000, half_reg[7:0], half_reg[15:8]})
      else $error("byte-swapped result wrong");
   swap_decode_a: assert property (
      accept && INSTR_IN[31:26] == 6'h1F && INSTR_IN[10:1] == 10'h316
      |=> op_reg.swap && state_reg == ST_ADDR)
      else $error("swap form not decoded");
   index_addr_a: assert property (
      state_reg == ST_ADDR && op_reg.indexed |=>
      ea_reg == ((op_reg.base == 5'h00) ? $past(INDEX_DATA_IN)
                 : $past(BASE_DATA_IN) + $past(INDEX_DATA_IN)))
      else $error("indexed address wrong");
   disp_addr_a: assert property (
      state_reg == ST_ADDR && !op_reg.indexed |=>
      ea_reg == ((op_reg.base == 5'h00) ? {{16{op_reg.imm[15]}}, op_reg.imm}
               : $past(BASE_DATA_IN) + {{16{op_reg.imm[15]}}, op_reg.imm}))
      else $error("displacement address wrong");
   disp_decode_a: assert property (
      accept && (INSTR_IN[31:26] == 6'h28 || INSTR_IN[31:26] == 6'h29) |=>
      op_reg.legal && !op_reg.indexed &&
      op_reg.update == $past(INSTR_IN[26]))
      else $error("displacement form not decoded");
   zext_data_a: assert property (TGT_WE_OUT && !op_reg.swap |->
      TGT_DATA_OUT == {16'h0000, half_reg})
      else $error("zero-extended result wrong");
   base_update_a: assert property (BASE_WE_OUT |-> TGT_WE_OUT &&
      op_reg.update && op_reg.base != 5'h00 && op_reg.base != op_reg.tgt &&
      BASE_DATA_OUT == MEM_ADDR_OUT && $past(MEM_ACK_IN, 2) &&
      !$past(MEM_ERR_IN, 2))
      else $error("illegal base update");
   gpr_only_a: assert property ((TGT_WE_OUT || BASE_WE_OUT) |->
      DONE_OUT && !ALIGN_FAULT_OUT && !STORAGE_FAULT_OUT)
      else $error("write outside a clean completion");
   upd_decode_a: assert property (
      accept && INSTR_IN[31:26] == 6'h1F && INSTR_IN[10:1] == 10'h14B
      |=> op_reg.update && op_reg.indexed)
      else $error("indexed update form not decoded");
   zx_decode_a: assert property (
      accept && INSTR_IN[31:26] == 6'h1F && INSTR_IN[10:1] == 10'h117
      |=> op_reg.indexed && !op_reg.update && !op_reg.swap)
      else $error("indexed form not decoded");
   field_take_a: assert property (accept |=>
      op_reg.tgt == $past(INSTR_IN[25:21]) &&
      op_reg.base == $past(INSTR_IN[20:16]) &&
      op_reg.index == $past(INSTR_IN[15:11]) &&
      op_reg.imm == $past(INSTR_IN[15:0]))
      else $error("instruction fields misplaced");
   commit_order_a: assert property (
      MEM_REQ_OUT && MEM_ACK_IN && !MEM_ERR_IN |=>
      !MEM_REQ_OUT ##1 TGT_WE_OUT)
      else $error("commit not after clean read");
   fault_block_a: assert property (
      MEM_REQ_OUT && MEM_ACK_IN && MEM_ERR_IN |=>
      STORAGE_FAULT_OUT ##1 !TGT_WE_OUT[*2])
      else $error("write after storage fault");

   swap_done_c: cover property (TGT_WE_OUT && op_reg.swap);
   update_done_c: cover property (BASE_WE_OUT);
   align_fault_c: cover property (ALIGN_FAULT_OUT);
   storage_fault_c: cover property (STORAGE_FAULT_OUT);

endmodule // halfword_load_decode

// file: core/hload_pkg.sv
// Shared constants, decoded-instruction types and states for the loader.
package hload_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Instruction field positions (LSB index and width, bit 31 = MSB).
   localparam int PRIMARY_LSB = 26;
   localparam int PRIMARY_W   = 6;
   localparam int TGT_LSB     = 21;
   localparam int BASE_LSB    = 16;
   localparam int INDEX_LSB   = 11;
   localparam int REG_W       = 5;
   localparam int EXT_LSB     = 1;
   localparam int EXT_W       = 10;
   localparam int IMM_LSB     = 0;
   localparam int IMM_W       = 16;

   ////////////////////////////////////////////////////////////////////////
   // Opcode values.
   localparam logic [5:0] OPC_INDEXED    = 6'h1F;  // Primary 31.
   localparam logic [5:0] OPC_ZEXT       = 6'h28;  // Primary 40.
   localparam logic [5:0] OPC_ZEXT_UPD   = 6'h29;  // Primary 41.
   localparam logic [9:0] XO_SWAP        = 10'h316; // Extended 790.
   localparam logic [9:0] XO_ZEXT_UPD_X  = 10'h14B; // Extended 331.
   localparam logic [9:0] XO_ZEXT_X      = 10'h117; // Extended 279.

   ////////////////////////////////////////////////////////////////////////
   // Reset values.
   localparam logic [31:0] WORD_RESET = 32'h0000_0000;
   localparam logic [15:0] HALF_RESET = 16'h0000;
   localparam logic [4:0]  SEL_RESET  = 5'h00;

   ////////////////////////////////////////////////////////////////////////
   // Decoded forms and the decoder's output bundle.
   typedef enum {
      FORM_NONE,
      FORM_SWAP_X,
      FORM_ZEXT_D,
      FORM_ZEXT_DU,
      FORM_ZEXT_XU,
      FORM_ZEXT_X
   } form_type;

   typedef struct packed {
      logic        legal;
      logic        indexed;
      logic        update;
      logic        swap;
      logic [4:0]  tgt;
      logic [4:0]  base;
      logic [4:0]  index;
      logic [15:0] imm;
   } decode_type;

   localparam decode_type DECODE_RESET = '0;

   typedef enum {
      ST_IDLE,
      ST_ADDR,
      ST_READ,
      ST_COMMIT
   } state_type;

endpackage

// file: core/hload_decoder.sv
// Combinational decoder for the five halfword load instruction forms.
`timescale 1ns/1ns
module hload_decoder
   import hload_pkg::*;
(
   // Instruction word in.
   input  wire logic [31:0] instr_in,
   // Decoded bundle out.
   output decode_type       dec_out
);

   logic [5:0] primary;
   logic [9:0] ext;
   form_type   form;

   assign primary = instr_in[PRIMARY_LSB +: PRIMARY_W];
   assign ext     = instr_in[EXT_LSB +: EXT_W];

   // Match primary opcode, then the extended opcode for the indexed group.
   always_comb begin
      form = FORM_NONE;
      if (primary == OPC_INDEXED) begin
         if (ext == XO_SWAP)            form = FORM_SWAP_X;
         else if (ext == XO_ZEXT_UPD_X) form = FORM_ZEXT_XU;
         else if (ext == XO_ZEXT_X)     form = FORM_ZEXT_X;
      end else if (primary == OPC_ZEXT) begin
         form = FORM_ZEXT_D;
      end else if (primary == OPC_ZEXT_UPD) begin
         form = FORM_ZEXT_DU;
      end
   end

   // Register and immediate fields sit at fixed places in every form.
   always_comb begin
      dec_out         = DECODE_RESET;
      dec_out.legal   = (form != FORM_NONE);
      dec_out.indexed = (form == FORM_SWAP_X) || (form == FORM_ZEXT_XU) ||
                        (form == FORM_ZEXT_X);
      dec_out.update  = (form == FORM_ZEXT_DU) || (form == FORM_ZEXT_XU);
      dec_out.swap    = (form == FORM_SWAP_X);
      dec_out.tgt     = instr_in[TGT_LSB +: REG_W];
      dec_out.base    = instr_in[BASE_LSB +: REG_W];
      dec_out.index   = instr_in[INDEX_LSB +: REG_W];
      dec_out.imm     = instr_in[IMM_LSB +: IMM_W];
   end

endmodule // hload_decoder

// file: dv/hload_partner.sv
// Register file and data memory model on the far side of the load unit.
`timescale 1ns/1ns
module hload_partner
   import hload_pkg::*;
(
   // Clock, reset and scenario knobs.
   input  wire logic        clk_in,
   input  wire logic        nrst_in,
   input  wire logic [3:0]  ack_delay_in,
   input  wire logic [31:0] err_addr_in,
   // Register file reads.
   input  wire logic [4:0]  base_sel_in,
   input  wire logic [4:0]  index_sel_in,
   output logic [31:0]      base_data_out,
   output logic [31:0]      index_data_out,
   // Memory read.
   input  wire logic        mem_req_in,
   input  wire logic [31:0] mem_addr_in,
   output logic             mem_ack_out,
   output logic [15:0]      mem_data_out,
   output logic             mem_err_out,
   // Register file writes.
   input  wire logic        tgt_we_in,
   input  wire logic [4:0]  tgt_sel_in,
   input  wire logic [31:0] tgt_data_in,
   input  wire logic        base_we_in,
   input  wire logic [31:0] base_wdata_in
);
   logic [31:0] regs [32];
   int          reads;
   logic [31:0] last_addr;
   logic [3:0]  wait_cnt;

   // Reads are combinational; entry zero holds junk so a base field of
   // zero that wrongly uses it shows up in the address.
   assign base_data_out  = regs[base_sel_in];
   assign index_data_out = regs[index_sel_in];

   // Writes land on the edge that samples the pulses.
   always @(posedge clk_in) begin
      if (tgt_we_in)
         regs[tgt_sel_in] <= tgt_data_in;
      if (base_we_in)
         regs[base_sel_in] <= base_wdata_in;
   end

   // One answer per request after a set wait; data and error lines toggle
   // outside the answer cycle so stale values are never mistaken for data.
   always @(posedge clk_in) begin
      if (!nrst_in) begin
         mem_ack_out  <= 1'b0;
         mem_data_out <= 16'h0000;
         mem_err_out  <= 1'b0;
         wait_cnt     <= 4'h0;
         reads        <= 0;
      end else if (mem_req_in && !mem_ack_out
                   && wait_cnt == ack_delay_in) begin
         mem_ack_out  <= 1'b1;
         mem_data_out <= {mem_addr_in[7:0], mem_addr_in[15:8] ^ 8'h3C};
         mem_err_out  <= (mem_addr_in == err_addr_in);
         reads        <= reads + 1;
         last_addr    <= mem_addr_in;
         wait_cnt     <= 4'h0;
      end else begin
         mem_ack_out  <= 1'b0;
         mem_data_out <= ~mem_data_out;
         mem_err_out  <= ~mem_err_out;
         wait_cnt     <= (mem_req_in && !mem_ack_out) ? wait_cnt + 4'h1
                                                      : 4'h0;
      end
   end
endmodule // hload_partner

// file: dv/test_halfword_load_decode.sv
// Self-checking testbench for the halfword load unit.
`timescale 1ns/1ns
module test_halfword_load_decode;
   import hload_pkg::*;
   logic        ref_clk = 1'b0;
   logic        nrst = 1'b0;
   logic        instr_valid = 1'b0;
   logic [31:0] instr = 32'h0000_0000;
   logic [3:0]  ack_delay = 4'h0;
   logic [31:0] err_addr = 32'hFFFF_FFFF;
   logic        instr_ready, illegal, mem_req, mem_ack, mem_err;
   logic        tgt_we, base_we, done, align_fault, storage_fault;
   logic [4:0]  base_sel, index_sel, tgt_sel;
   logic [15:0] mem_data;
   logic [31:0] base_data, index_data, mem_addr, tgt_data, base_wdata;
   int          miscompares = 0;
   int          check_count = 0;

   // Clock at 20 MHz.
   always #25 ref_clk = ~ref_clk;

   halfword_load_decode #(.XLEN(32)) dut (
      .REF_CLK_IN(ref_clk), .NRST_IN(nrst), .INSTR_VALID_IN(instr_valid),
      .INSTR_IN(instr), .INSTR_READY_OUT(instr_ready),
      .ILLEGAL_OUT(illegal), .BASE_SEL_OUT(base_sel),
      .INDEX_SEL_OUT(index_sel), .BASE_DATA_IN(base_data),
      .INDEX_DATA_IN(index_data), .MEM_REQ_OUT(mem_req),
      .MEM_ADDR_OUT(mem_addr), .MEM_ACK_IN(mem_ack),
      .MEM_DATA_IN(mem_data), .MEM_ERR_IN(mem_err),
      .TGT_WE_OUT(tgt_we), .TGT_SEL_OUT(tgt_sel), .TGT_DATA_OUT(tgt_data),
      .BASE_WE_OUT(base_we), .BASE_DATA_OUT(base_wdata), .DONE_OUT(done),
      .ALIGN_FAULT_OUT(align_fault), .STORAGE_FAULT_OUT(storage_fault));

   hload_partner far (
      .clk_in(ref_clk), .nrst_in(nrst), .ack_delay_in(ack_delay),
      .err_addr_in(err_addr), .base_sel_in(base_sel),
      .index_sel_in(index_sel), .base_data_out(base_data),
      .index_data_out(index_data), .mem_req_in(mem_req),
      .mem_addr_in(mem_addr), .mem_ack_out(mem_ack),
      .mem_data_out(mem_data), .mem_err_out(mem_err),
      .tgt_we_in(tgt_we), .tgt_sel_in(tgt_sel), .tgt_data_in(tgt_data),
      .base_we_in(base_we), .base_wdata_in(base_wdata));

   ////////////////////////////////////////////////////////////////////////
   // Verdict and comparisons.
   task automatic stop_test();
      if (miscompares == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t word %h expected %h", $time, got, exp);
      end
   endtask

   task automatic check_flags(input logic [3:0] got, input logic [3:0] exp);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t flags %b expected %b", $time, got, exp);
      end
   endtask

   // Expected storage halfword, mirroring the memory model's pattern.
   function automatic logic [15:0] mem(input logic [31:0] a);
      return {a[7:0], a[15:8] ^ 8'h3C};
   endfunction

   function automatic logic [31:0] dform(input logic [5:0] op,
      input logic [4:0] t, input logic [4:0] b, input logic [15:0] imm);
      return {op, t, b, imm};
   endfunction

   // Bit zero is the ignored trailing bit of the indexed forms.
   function automatic logic [31:0] xform(input logic [4:0] t,
      input logic [4:0] b, input logic [4:0] i, input logic [9:0] xo);
      return {OPC_INDEXED, t, b, i, xo, 1'b1};
   endfunction

   // Offers one word, waits for its end, checks flags, reads and address.
   task automatic exec(input logic [31:0] word, input logic [2:0] flags,
      input int n_reads, input logic [31:0] ea);
      int          r0;
      logic [3:0]  seen;
      r0 = far.reads;
      @(posedge ref_clk);
      instr <= word;
      instr_valid <= 1'b1;
      @(posedge ref_clk);
      instr_valid <= 1'b0;
      // The illegal pulse stands in the cycle right after the take edge,
      // so the first look comes before the next edge.
      for (int n = 0; n < 40; n++) begin
         #1;
         if (done === 1'b1 || illegal === 1'b1)
            break;
         @(posedge ref_clk);
      end
      // The top bit catches a word that never finished.
      seen = {done | illegal, illegal, align_fault, storage_fault};
      check_flags(seen, {1'b1, flags});
      @(posedge ref_clk);
      #1;
      check_word(far.reads - r0, n_reads);
      if (n_reads > 0)
         check_word(far.last_addr, ea);
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Scenarios.
   task automatic t_disp();
      far.regs[3] = 32'h0000_1234;
      exec(dform(OPC_ZEXT, 7, 3, 16'hFFF0), 3'h0, 1, 32'h1224);
      check_word(far.regs[7], {16'h0000, mem(32'h1224)});
      exec(dform(OPC_ZEXT, 8, 0, 16'h8002), 3'h0, 1, 32'hFFFF8002);
      check_word(far.regs[8], {16'h0000, mem(32'h8002)});
   endtask

   task automatic t_disp_upd();
      far.regs[4] = 32'h0000_2000;
      far.regs[5] = 32'h0000_3000;
      exec(dform(OPC_ZEXT_UPD, 9, 4, 16'h0010), 3'h0, 1, 32'h2010);
      check_word(far.regs[9], {16'h0000, mem(32'h2010)});
      check_word(far.regs[4], 32'h0000_2010);
      exec(dform(OPC_ZEXT_UPD, 5, 5, 16'h0002), 3'h0, 1, 32'h3002);
      check_word(far.regs[5], {16'h0000, mem(32'h3002)});
   endtask

   task automatic t_indexed();
      far.regs[6] = 32'h0000_4002;
      far.regs[12] = 32'h0000_0100;
      far.regs[13] = 32'h0000_0206;
      exec(xform(10, 0, 6, XO_ZEXT_X), 3'b000, 1, 32'h4002);
      check_word(far.regs[10], {16'h0000, mem(32'h4002)});
      exec(xform(11, 12, 13, XO_ZEXT_X), 3'b000, 1, 32'h0306);
      check_word(far.regs[11], {16'h0000, mem(32'h0306)});
   endtask

   task automatic t_indexed_upd();
      far.regs[14] = 32'h0000_0500;
      far.regs[15] = 32'h0000_0004;
      exec(xform(16, 14, 15, XO_ZEXT_UPD_X), 3'h0, 1, 32'h0504);
      check_word(far.regs[16], {16'h0000, mem(32'h0504)});
      check_word(far.regs[14], 32'h0000_0504);
      exec(xform(17, 0, 15, XO_ZEXT_UPD_X), 3'h0, 1, 32'h0004);
      check_word(far.regs[0], 32'hDEAD_0000);
      check_word(far.regs[17], {16'h0000, mem(32'h0004)});
   endtask

   // A slow memory answer is used here to stretch the request.
   task automatic t_swap();
      logic [15:0] d;
      d = mem(32'h0608);
      far.regs[18] = 32'h0000_0600;
      far.regs[19] = 32'h0000_0008;
      ack_delay <= 4'h3;
      exec(xform(20, 18, 19, XO_SWAP), 3'b000, 1, 32'h0608);
      check_word(far.regs[20], {16'h0000, d[7:0], d[15:8]});
      ack_delay <= 4'h0;
   endtask

   task automatic t_faults();
      far.regs[21] = 32'h0000_0701;
      far.regs[22] = 32'hFFFF_FFFF;
      exec(dform(OPC_ZEXT_UPD, 22, 21, 16'h0000), 3'h2, 0, 32'h0);
      check_word(far.regs[22], 32'hFFFF_FFFF);
      check_word(far.regs[21], 32'h0000_0701);
      err_addr <= 32'h0000_0800;
      far.regs[23] = 32'h0000_0800;
      far.regs[24] = 32'h0000_0000;
      exec(xform(22, 23, 24, XO_ZEXT_UPD_X), 3'h1, 1, 32'h0800);
      check_word(far.regs[22], 32'hFFFF_FFFF);
      check_word(far.regs[23], 32'h0000_0800);
   endtask

   // Near-miss codes must be refused without any memory read.
   task automatic t_illegal();
      exec(xform(1, 2, 3, 10'h157), 3'b100, 0, 32'h0);
      exec(xform(1, 2, 3, 10'h177), 3'b100, 0, 32'h0);
      exec(xform(1, 2, 3, 10'h317), 3'b100, 0, 32'h0);
      exec(dform(6'h2B, 1, 2, 16'h0000), 3'b100, 0, 32'h0);
   endtask

   // Main sequence: reset for four cycles, then every scenario.
   initial begin
      for (int i = 0; i < 32; i++)
         far.regs[i] = 32'h0000_0000;
      far.regs[0] = 32'hDEAD_0000;
      repeat (4) @(posedge ref_clk);
      nrst <= 1'b1;
      // Idle after release: ready up, no request and no register writes.
      @(posedge ref_clk);
      #1;
      check_flags({instr_ready, mem_req, tgt_we, base_we}, 4'h8);
      t_disp();
      t_disp_upd();
      t_indexed();
      t_indexed_upd();
      t_swap();
      t_faults();
      t_illegal();
      stop_test();
   end

   // Watchdog: the scenarios need well under a thousand cycles.
   initial begin
      #(50 * 3000);
      miscompares++;
      stop_test();
   end
endmodule // test_halfword_load_decode
